//--- rtl/drs_sequencer.sv
// device reset sequencer: merges reset sources, times the power-up, releases system reset
// assumes all inputs synchronous to clk; fuses stable; core drives flag write strobes
module drs_sequencer #(
   parameter int PWRT4_CYC  = drs_pkg::POWERUP_TIMER_4MS_CYC,  // 4 ms power-up delay in clocks
   parameter int PWRT16_CYC = drs_pkg::POWERUP_TIMER_16MS_CYC, // 16 ms
   parameter int PWRT64_CYC = drs_pkg::POWERUP_TIMER_64MS_CYC  // 64 ms
) (
   input  wire logic                 clk,            // 125 MHz clock
   input  wire logic                 sys_rst,        // sync reset, high
   input  drs_pkg::drs_src_t         src,            // reset sources
   input  drs_pkg::drs_osc_cfg_t     oscCfg,         // oscillator fuses and modes
   input  wire logic [7:0]           borPorCfg,      // brownout_poweron_config_word
   input  wire logic [15:0]          oscCtrl,        // oscillator_control_register
   input  wire logic                 oscTick,        // one pulse per oscillator period
   input  wire logic                 flagWrEn,       // software write to cause flags
   input  wire logic [15:0]          flagWrData,     // value written
   output logic                      systemResetSignal_q, // system reset, high
   output logic [1:0]                clkSel_q,       // oscillator source after reset
   output logic                      clkRelease_q,   // system clock released to core
   output logic                      wakeUp_q,       // one-cycle wake from sleep/idle
   output logic [1:0]                tripSel_q,      // brownout_trip_select to comparator
   output logic                      borActive_q,    // brownout detector enabled
   output logic [15:0]               resetCause_q    // reset_cause_register
);
   typedef enum logic [2:0] {
      DRS_RUN    = 3'b000,
      DRS_HOLD   = 3'b001,
      DRS_PORDLY = 3'b010,
      DRS_PWRDLY = 3'b011,
      DRS_SYNC   = 3'b100
   } drs_state_t;

   drs_state_t   state_q;
   logic [1:0]   icyc_q;
   logic [2:0]   mclrCnt_q;
   logic         mclrLow_q;
   logic         swrPend_q;
   logic         brownOut;
   logic         wdtReset;
   logic         anySrc;
   logic         powerSrc;
   logic         porLoad;
   logic         pwrLoad;
   logic         porDone;
   logic         pwrDone;
   logic [31:0]  pwrtCyc;
   logic [drs_pkg::OST_W:0] ost_q;
   logic         icycEdge;

   assign icycEdge = (icyc_q == 2'(drs_pkg::ICYC_DIV - 1));
   assign brownOut = src.brownOut && borPorCfg[drs_pkg::CFG_BROWNOUT_ENABLE_FUSE_BIT];
   assign wdtReset = src.watchdogTimeout && !src.sleepOrIdle;
   assign powerSrc = src.powerOnPulse || brownOut;
   assign anySrc   = powerSrc || mclrLow_q || wdtReset || src.resetInstr;

   always_comb begin
      unique case (borPorCfg[drs_pkg::CFG_POWERUP_TIMER_LO +: 2])
         2'h0:    pwrtCyc = 32'h0;
         2'h1:    pwrtCyc = 32'(PWRT4_CYC);
         2'h2:    pwrtCyc = 32'(PWRT16_CYC);
         2'h3:    pwrtCyc = 32'(PWRT64_CYC);
      endcase
   end

   // power-up timer restarts on every power event, power-on timer on power-on only, so each recovery gets a full delay
   assign porLoad = src.powerOnPulse;
   assign pwrLoad = powerSrc || (state_q == DRS_PORDLY && !porDone);

   drs_counter #(.W(drs_pkg::CNT_W)) uPorTimer (
      .clk     (clk),
      .sys_rst (sys_rst),
      .load    (porLoad),
      .loadVal (32'(drs_pkg::POR_DELAY_CYC)),
      .done    (porDone)
   );

   drs_counter #(.W(drs_pkg::CNT_W)) uPwrTimer (
      .clk     (clk),
      .sys_rst (sys_rst),
      .load    (pwrLoad),
      .loadVal (pwrtCyc),
      .done    (pwrDone)
   );

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         icyc_q <= 2'h0;
      end else begin
         icyc_q <= icycEdge ? 2'h0 : icyc_q + 2'h1;
      end
   end

   // master clear filter: assert only after the pin has been low for the minimum width
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mclrCnt_q <= 3'h0;
         mclrLow_q <= 1'b0;
      end else if (src.masterClearN) begin
         mclrCnt_q <= 3'h0;
         mclrLow_q <= 1'b0;
      end else if (mclrCnt_q != 3'(drs_pkg::MASTER_CLEAR_PIN_MIN_CYC - 1)) begin
         mclrCnt_q <= mclrCnt_q + 3'h1;
      end else begin
         mclrLow_q <= 1'b1;
      end
   end

   // power-on pulse implies brownout wait too; pin/wdt/instr skip the delays, one hold cycle then sync
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= DRS_PORDLY;
         swrPend_q <= 1'b0;
      end else if (anySrc) begin
         state_q   <= src.powerOnPulse ? DRS_PORDLY :
                      (brownOut ? DRS_PWRDLY : DRS_HOLD);
         swrPend_q <= 1'b0;
      end else begin
         unique case (state_q)
            DRS_RUN:    state_q <= DRS_RUN;
            DRS_HOLD:   state_q <= DRS_SYNC;
            DRS_PORDLY: if (porDone) state_q <= DRS_PWRDLY;
            DRS_PWRDLY: if (pwrDone) state_q <= DRS_SYNC;
            DRS_SYNC:   if (icycEdge) state_q <= DRS_RUN;
            default:    state_q <= DRS_PORDLY;
         endcase
      end
   end

   // reset level; the pin and watchdog assert it the cycle after they are seen
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         systemResetSignal_q <= 1'b1;
      end else begin
         systemResetSignal_q <= anySrc ||
                                !(state_q == DRS_SYNC && icycEdge) &&
                                (state_q != DRS_RUN);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clkSel_q <= 2'h0;
      end else if (powerSrc || !oscCfg.clkSwitchEn) begin
         clkSel_q <= oscCfg.fuseOscSel;
      end else if (mclrLow_q || wdtReset || src.resetInstr) begin
         clkSel_q <= oscCtrl[drs_pkg::OSC_CURRENT_OSCILLATOR_SELECT_LO +: 2];
      end
   end

   // oscillator start-up timer counts oscillator periods after a brownout or power-on when a crystal is selected
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ost_q <= '0;
      end else if (powerSrc && oscCfg.crystalSel) begin
         ost_q <= (drs_pkg::OST_W + 1)'(drs_pkg::OST_PERIODS);
      end else if (oscTick && ost_q != '0) begin
         ost_q <= ost_q - (drs_pkg::OST_W + 1)'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clkRelease_q <= 1'b0;
      end else begin
         clkRelease_q <= (ost_q == '0) && !(powerSrc && oscCfg.crystalSel) &&
                         (!oscCfg.pllSel || oscCtrl[drs_pkg::OSC_LOCK_BIT]);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wakeUp_q <= 1'b0;
      end else begin
         wakeUp_q <= src.watchdogTimeout && src.sleepOrIdle;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tripSel_q   <= 2'h0;
         borActive_q <= 1'b0;
      end else begin
         tripSel_q   <= borPorCfg[drs_pkg::CFG_BROWNOUT_TRIP_SELECT_LO +: 2];
         borActive_q <= borPorCfg[drs_pkg::CFG_BROWNOUT_ENABLE_FUSE_BIT];
      end
   end

   // hardware sets win over a same-cycle software write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         resetCause_q <= drs_pkg::RC_RESET;
      end else begin
         resetCause_q <= flagWrEn ? flagWrData : resetCause_q;
         if (src.powerOnPulse) begin
            resetCause_q <= 16'h0000;
            resetCause_q[drs_pkg::RC_POR] <= 1'b1;
            resetCause_q[drs_pkg::RC_BOR] <= 1'b1;
         end else begin
            if (brownOut)    resetCause_q[drs_pkg::RC_BOR]  <= 1'b1;
            if (mclrLow_q)   resetCause_q[drs_pkg::RC_PIN_RESET_FLAG] <= 1'b1;
            if (src.resetInstr) resetCause_q[drs_pkg::RC_SWR] <= 1'b1;
            if (src.watchdogTimeout) resetCause_q[drs_pkg::RC_WDTO] <= 1'b1;
         end
      end
   end

   a_pin_sets_flag: assert property (@(posedge clk) disable iff (sys_rst)
      mclrLow_q && !src.powerOnPulse |=> resetCause_q[drs_pkg::RC_PIN_RESET_FLAG])
      else $error("pin reset flag not set");
   a_por_sets_both: assert property (@(posedge clk) disable iff (sys_rst)
      src.powerOnPulse |=> resetCause_q[1:0] == 2'h3)
      else $error("power-on flags not set");
   a_bor_sets_flag: assert property (@(posedge clk) disable iff (sys_rst)
      brownOut |=> resetCause_q[drs_pkg::RC_BOR])
      else $error("brownout flag not set");
   a_source_holds_reset: assert property (@(posedge clk) disable iff (sys_rst)
      anySrc |=> systemResetSignal_q)
      else $error("reset dropped while source active");
   a_wdt_sleep_wakes: assert property (@(posedge clk) disable iff (sys_rst)
      src.watchdogTimeout && src.sleepOrIdle && !powerSrc && !mclrLow_q && !src.resetInstr
      && state_q == DRS_RUN |=> wakeUp_q && !systemResetSignal_q)
      else $error("watchdog in sleep did not wake");
   a_release_on_edge: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(systemResetSignal_q) |-> $past(icycEdge))
      else $error("release off instruction edge");
   a_fuse_clk_pwr: assert property (@(posedge clk) disable iff (sys_rst)
      powerSrc |=> clkSel_q == $past(oscCfg.fuseOscSel))
      else $error("fuse clock not taken");
   a_pll_lock_gate: assert property (@(posedge clk) disable iff (sys_rst)
      oscCfg.pllSel && !oscCtrl[drs_pkg::OSC_LOCK_BIT] |=> !clkRelease_q)
      else $error("clock released before lock");
   a_swr_releases: assert property (@(posedge clk) disable iff (sys_rst)
      src.resetInstr && !powerSrc ##1 !anySrc [*6] |=> !systemResetSignal_q)
      else $error("software reset not released");

   c_por_release: cover property (@(posedge clk) disable iff (sys_rst)
      state_q == DRS_PWRDLY ##[1:1000] $fell(systemResetSignal_q));
   c_pin_reset: cover property (@(posedge clk) disable iff (sys_rst) $rose(mclrLow_q));
   c_wdt_wake: cover property (@(posedge clk) disable iff (sys_rst) wakeUp_q);
   c_bor_sleep: cover property (@(posedge clk) disable iff (sys_rst)
      brownOut && src.sleepOrIdle);
   c_pll_release: cover property (@(posedge clk) disable iff (sys_rst)
      oscCfg.pllSel ##1 $rose(clkRelease_q));

   // pin filter: a seen reset needs the full low run, a high pin clears it at once
   a_pin_high_clears: assert property (@(posedge clk) disable iff (sys_rst)
      src.masterClearN |=> !mclrLow_q)
      else $error("pin filter not cleared");
   a_pin_filter_len: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(mclrLow_q) |-> !$past(src.masterClearN, 1) && !$past(src.masterClearN, 2) &&
      !$past(src.masterClearN, 3) && !$past(src.masterClearN, 4))
      else $error("short pin pulse accepted");

   // clock source choice per reset type
   a_pin_keeps_clk: assert property (@(posedge clk) disable iff (sys_rst)
      mclrLow_q && !powerSrc && oscCfg.clkSwitchEn
      |=> clkSel_q == $past(oscCtrl[drs_pkg::OSC_CURRENT_OSCILLATOR_SELECT_LO +: 2]))
      else $error("pin reset changed clock");
   a_swr_keeps_clk: assert property (@(posedge clk) disable iff (sys_rst)
      src.resetInstr && !powerSrc && oscCfg.clkSwitchEn
      |=> clkSel_q == $past(oscCtrl[drs_pkg::OSC_CURRENT_OSCILLATOR_SELECT_LO +: 2]))
      else $error("instruction reset changed clock");
   a_wdt_keeps_clk: assert property (@(posedge clk) disable iff (sys_rst)
      wdtReset && !powerSrc && oscCfg.clkSwitchEn
      |=> clkSel_q == $past(oscCtrl[drs_pkg::OSC_CURRENT_OSCILLATOR_SELECT_LO +: 2]))
      else $error("watchdog reset changed clock");
   a_no_switch_fuse: assert property (@(posedge clk) disable iff (sys_rst)
      !oscCfg.clkSwitchEn |=> clkSel_q == $past(oscCfg.fuseOscSel))
      else $error("fixed clock not from fuses");

   // fuse copies to the brownout comparator
   a_trip_copy: assert property (@(posedge clk) disable iff (sys_rst)
      !sys_rst |=> tripSel_q == $past(borPorCfg[drs_pkg::CFG_BROWNOUT_TRIP_SELECT_LO +: 2]))
      else $error("trip select not copied");
   a_bor_enable_copy: assert property (@(posedge clk) disable iff (sys_rst)
      !sys_rst |=> borActive_q == $past(borPorCfg[drs_pkg::CFG_BROWNOUT_ENABLE_FUSE_BIT]))
      else $error("brownout enable not copied");
   a_bor_fuse_off: assert property (@(posedge clk) disable iff (sys_rst)
      src.brownOut && !anySrc && state_q == DRS_RUN |=> !systemResetSignal_q)
      else $error("disabled brownout reset the device");
   a_bor_in_sleep: assert property (@(posedge clk) disable iff (sys_rst)
      brownOut && src.sleepOrIdle |=> systemResetSignal_q)
      else $error("brownout ignored in sleep");

   // delay sequencing
   a_por_restart: assert property (@(posedge clk) disable iff (sys_rst)
      src.powerOnPulse |=> state_q == DRS_PORDLY)
      else $error("power-on did not restart delay");
   a_bor_restart: assert property (@(posedge clk) disable iff (sys_rst)
      brownOut && !src.powerOnPulse |=> state_q == DRS_PWRDLY)
      else $error("brownout did not restart delay");
   a_por_dly_hold: assert property (@(posedge clk) disable iff (sys_rst)
      state_q == DRS_PORDLY |=> systemResetSignal_q)
      else $error("reset dropped in power-on delay");
   a_pwr_dly_hold: assert property (@(posedge clk) disable iff (sys_rst)
      state_q == DRS_PWRDLY |=> systemResetSignal_q)
      else $error("reset dropped in power-up delay");

   // start-up timer keeps the clock back while it runs
   a_ost_load: assert property (@(posedge clk) disable iff (sys_rst)
      powerSrc && oscCfg.crystalSel
      |=> ost_q == (drs_pkg::OST_W + 1)'(drs_pkg::OST_PERIODS))
      else $error("start-up timer not loaded");
   a_ost_withholds: assert property (@(posedge clk) disable iff (sys_rst)
      ost_q != '0 |=> !clkRelease_q)
      else $error("clock released during start-up");

   // software access to the cause flags
   a_sw_write_lands: assert property (@(posedge clk) disable iff (sys_rst)
      flagWrEn && !src.powerOnPulse && !brownOut && !mclrLow_q && !src.resetInstr &&
      !src.watchdogTimeout |=> resetCause_q == $past(flagWrData))
      else $error("flag write lost");
   a_sw_write_no_rst: assert property (@(posedge clk) disable iff (sys_rst)
      flagWrEn && !anySrc && state_q == DRS_RUN |=> !systemResetSignal_q)
      else $error("flag write caused reset");
   a_wake_cause: assert property (@(posedge clk) disable iff (sys_rst)
      wakeUp_q |-> $past(src.watchdogTimeout) && $past(src.sleepOrIdle))
      else $error("wake without sleeping watchdog");
endmodule // drs_sequencer

//--- rtl/drs_pkg.sv
// package for the device reset sequencer: constants, config word layout, shared types
// assumes a single 125 MHz clock domain
package drs_pkg;
   localparam int CLK_MHZ            = 125;
   localparam int POR_DELAY_NS       = 10000;                   // power_on_delay, 10 us
   localparam int POR_DELAY_CYC      = (POR_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int POWERUP_TIMER_4MS_US        = 4000;
   localparam int POWERUP_TIMER_16MS_US       = 16000;
   localparam int POWERUP_TIMER_64MS_US       = 64000;
   localparam int POWERUP_TIMER_4MS_CYC       = POWERUP_TIMER_4MS_US * CLK_MHZ;
   localparam int POWERUP_TIMER_16MS_CYC      = POWERUP_TIMER_16MS_US * CLK_MHZ;
   localparam int POWERUP_TIMER_64MS_CYC      = POWERUP_TIMER_64MS_US * CLK_MHZ;
   localparam int OST_PERIODS        = 1024;                    // oscillator start-up count
   localparam int OST_W              = 10;
   localparam int MASTER_CLEAR_PIN_MIN_CYC       = 4;                       // pin glitch filter width
   localparam int ICYC_DIV           = 4;                       // clocks per instruction cycle
   localparam int CNT_W              = 32;
   // brownout_poweron_config_word bit positions
   localparam int CFG_POWERUP_TIMER_LO        = 0;                       // powerup_delay_select 1:0
   localparam int CFG_BROWNOUT_TRIP_SELECT_LO        = 4;                       // brownout_trip_select 5:4
   localparam int CFG_BROWNOUT_ENABLE_FUSE_BIT      = 7;                       // brownout_enable_fuse
   // reset_cause_register bit positions
   localparam int RC_POR             = 0;
   localparam int RC_BOR             = 1;
   localparam int RC_SWR             = 6;
   localparam int RC_PIN_RESET_FLAG            = 7;
   localparam int RC_WDTO            = 4;
   localparam int OSC_CURRENT_OSCILLATOR_SELECT_LO        = 12;                      // current_oscillator_select 13:12
   localparam int OSC_LOCK_BIT       = 5;
   localparam logic [15:0] RC_RESET  = 16'h0003;

   typedef struct packed {
      logic       powerOnPulse;   // supply rise detected
      logic       brownOut;       // supply below brownout_trip_voltage
      logic       masterClearN;   // master_clear_pin, low active
      logic       resetInstr;     // software reset instruction executed
      logic       watchdogTimeout;
      logic       sleepOrIdle;    // core is in a power-saving state
   } drs_src_t;

   typedef struct packed {
      logic       clkSwitchEn;
      logic [1:0] fuseOscSel;     // from osc_source_bits
      logic       crystalSel;     // primary_osc_mode_bits pick a crystal
      logic       pllSel;
   } drs_osc_cfg_t;
endpackage

//--- rtl/drs_counter.sv
// down-counting delay timer with restart, used for the power-on and power-up waits
// assumes synchronous active-high reset on clk
module drs_counter #(
   parameter int W = 32
) (
   input  wire logic         clk,     // system clock
   input  wire logic         sys_rst, // sync reset
   input  wire logic         load,    // restart with loadVal
   input  wire logic [W-1:0] loadVal, // cycles to wait
   output logic              done     // count reached zero
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= loadVal;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - W'(1);
      end
   end

   assign done = (cnt_q == '0) && !load;
endmodule // drs_counter

//--- verif/drs_partner.sv
// far-side model: crystal oscillator period ticks and the oscillator control register
// assumes curOsc and pllSel come from the bench, changed at the falling edge
module drs_partner #(
   parameter int LOCK_CYC = 30
) (
   input  wire logic       clk,     // system clock
   input  wire logic       sys_rst, // sync reset, high
   input  wire logic       pllSel,  // loop selected, starts locking
   input  wire logic [1:0] curOsc,  // running oscillator code
   output logic            oscTick, // one pulse per oscillator period
   output logic [15:0]     oscCtrl  // oscillator control register image
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tick_q;
   int   lockCnt;
   // oscillator runs at half the clock rate, so start-up takes twice its period count
   always @(posedge clk) begin
      tick_q <= sys_rst ? 1'b0 : ~tick_q;
   end
   always @(posedge clk) begin
      if (sys_rst || !pllSel) begin
         lockCnt <= 0;
      end else if (lockCnt < LOCK_CYC) begin
         lockCnt <= lockCnt + 1;
      end
   end
   assign oscTick = tick_q;
   assign oscCtrl = {2'h0, curOsc, 6'h00, lockCnt == LOCK_CYC, 5'h00};
endmodule // drs_partner

//--- verif/drs_sequencer_tb.sv
// self-checking bench for the reset sequencer: one task per scenario
// assumes shortened power-up delays; inputs change at the falling edge
module drs_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P4 = 20;
   localparam int P16 = 40;
   logic                  clk = 1'b0;
   logic                  sys_rst = 1'b1;
   drs_pkg::drs_src_t     src = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
   drs_pkg::drs_osc_cfg_t oscCfg = '{1'b1, 2'h2, 1'b1, 1'b0};
   logic [7:0]            borPorCfg = 8'h91;
   logic [1:0]            curOsc = 2'h1;
   logic                  flagWrEn = 1'b0;
   logic [15:0]           flagWrData = 16'h0000;
   logic [15:0]           oscCtrl;
   logic                  oscTick, system_reset_signal, clkRelease, wakeUp, borActive;
   logic [1:0]            clkSel, tripSel;
   logic [15:0]           cause;
   int                    n_mismatch = 0;
   int                    n_compared = 0;
   int                    cycles = 0;
   int                    n;
   always #4 clk = ~clk;
   drs_partner u_drs_partner (.clk(clk), .sys_rst(sys_rst), .pllSel(oscCfg.pllSel),
      .curOsc(curOsc), .oscTick(oscTick), .oscCtrl(oscCtrl));
   drs_sequencer #(.PWRT4_CYC(P4), .PWRT16_CYC(P16), .PWRT64_CYC(80)) u_drs_sequencer (
      .clk(clk), .sys_rst(sys_rst), .src(src), .oscCfg(oscCfg), .borPorCfg(borPorCfg),
      .oscCtrl(oscCtrl), .oscTick(oscTick), .flagWrEn(flagWrEn), .flagWrData(flagWrData),
      .systemResetSignal_q(system_reset_signal), .clkSel_q(clkSel), .clkRelease_q(clkRelease),
      .wakeUp_q(wakeUp), .tripSel_q(tripSel), .borActive_q(borActive), .resetCause_q(cause));
   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ceiling well above the roughly 2300 cycles the scenarios need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 12000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic waitRel(input int maxCyc);
      n = 0;
      while (system_reset_signal !== 1'b0 && n < maxCyc) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic clearFlags();
      @(negedge clk);
      flagWrEn = 1'b1;
      @(negedge clk);
      flagWrEn = 1'b0;
      tick(1);
      chk(cause, 16'h0000, "flag clear");
      chk(16'(system_reset_signal), 16'h0000, "reset after flag write");
   endtask
   task automatic pinLow(input int k);
      src.masterClearN = 1'b0;
      tick(k);
      src.masterClearN = 1'b1;
   endtask
   task automatic testPor();
      tick(6);
      sys_rst = 1'b0;
      src.powerOnPulse = 1'b1;
      tick(1);
      src.powerOnPulse = 1'b0;
      waitRel(1400);
      chk(16'(n >= 1250 + P4 && n <= 1250 + P4 + 8), 16'h0001, "por hold");
      chk(cause, 16'h0003, "por flags");
      chk(16'(clkSel), 16'h0002, "por clock");
      chk(16'(clkRelease), 16'h0000, "clock held by start-up timer");
      chk(16'({borActive, tripSel}), 16'h0005, "bor fuse copy");
      tick(800);
      chk(16'(clkRelease), 16'h0001, "clock after start-up timer");
      $display("power-on test done");
   endtask
   task automatic testPin();
      clearFlags();
      pinLow(3);
      tick(4);
      chk(16'(system_reset_signal), 16'h0000, "short pin pulse");
      pinLow(8);
      chk(16'(system_reset_signal), 16'h0001, "pin reset");
      waitRel(10);
      chk(16'(n <= 8), 16'h0001, "pin release");
      chk(cause, 16'h0080, "pin flag");
      chk(16'(clkSel), 16'h0001, "pin clock");
      $display("pin test done");
   endtask
   task automatic testSwr();
      clearFlags();
      curOsc = 2'h3;
      src.resetInstr = 1'b1;
      tick(1);
      src.resetInstr = 1'b0;
      tick(1);
      chk(16'(system_reset_signal), 16'h0001, "instruction reset");
      waitRel(10);
      chk(16'(n <= 8), 16'h0001, "instruction release");
      chk(cause, 16'h0040, "instruction flag");
      chk(16'(clkSel), 16'h0003, "instruction clock");
      $display("instruction test done");
   endtask
   task automatic testWdt();
      logic seen;
      clearFlags();
      seen = 1'b0;
      src.sleepOrIdle = 1'b1;
      src.watchdogTimeout = 1'b1;
      tick(1);
      seen = wakeUp;
      src.watchdogTimeout = 1'b0;
      repeat (3) begin
         tick(1);
         seen = seen | wakeUp;
      end
      chk(16'({seen, system_reset_signal}), 16'h0002, "watchdog wakes only");
      src.sleepOrIdle = 1'b0;
      curOsc = 2'h0;
      src.watchdogTimeout = 1'b1;
      tick(1);
      src.watchdogTimeout = 1'b0;
      tick(1);
      chk(16'(system_reset_signal), 16'h0001, "watchdog reset");
      waitRel(10);
      chk(cause, 16'h0010, "watchdog flag");
      chk(16'(clkSel), 16'h0000, "watchdog clock");
      $display("watchdog test done");
   endtask
   task automatic testBor();
      clearFlags();
      borPorCfg = 8'h02;
      src.brownOut = 1'b1;
      tick(3);
      src.brownOut = 1'b0;
      chk(16'(system_reset_signal), 16'h0000, "disabled brownout");
      borPorCfg = 8'hA2;
      src.sleepOrIdle = 1'b1;
      src.brownOut = 1'b1;
      tick(5);
      chk(16'({tripSel, system_reset_signal}), 16'h0005, "brownout in sleep");
      src.brownOut = 1'b0;
      tick(20);
      src.brownOut = 1'b1;
      tick(2);
      src.brownOut = 1'b0;
      waitRel(60);
      chk(16'(n >= P16 && n <= P16 + 8), 16'h0001, "brownout hold");
      chk(cause, 16'h0002, "brownout flag");
      chk(16'(clkSel), 16'h0002, "brownout clock");
      src.sleepOrIdle = 1'b0;
      $display("brownout test done");
   endtask
   task automatic testPll();
      oscCfg.pllSel = 1'b1;
      tick(2);
      chk(16'(clkRelease), 16'h0000, "clock held for lock");
      tick(35);
      chk(16'(clkRelease), 16'h0001, "clock after lock");
      oscCfg.pllSel = 1'b0;
      $display("lock test done");
   endtask
   task automatic testNoSwitch();
      oscCfg.clkSwitchEn = 1'b0;
      oscCfg.fuseOscSel = 2'h0;
      curOsc = 2'h3;
      pinLow(8);
      waitRel(10);
      chk(16'(clkSel), 16'h0000, "fixed clock source");
      $display("no-switch test done");
   endtask
   initial begin
      testPor();
      testPll();
      testPin();
      testSwr();
      testWdt();
      testBor();
      testNoSwitch();
      print_verdict();
   end
endmodule // drs_sequencer_tb
